// ### dv/storage_model.sv
`timescale 1ns/1ps

// =====================================================
// core storage: read answers within the request cycle, write on request
module storage_model (
	input wire logic clk,
	input wire sste_pkg::mem_req_s mem_out,
	output sste_pkg::word_s mem_rdata
);

	sste_pkg::word_s mem [0:32767];
	sste_pkg::word_s idle_reg;

	initial begin
		idle_reg = 36'h0_0000_0000;
	end

	always @(posedge clk) begin
		if (mem_out.req && mem_out.we) begin
			mem[mem_out.addr] <= mem_out.wdata;
		end
		idle_reg <= ~idle_reg;
	end

	// the design takes read data at the edge that ends its request cycle
	// outside a read the bus flips each cycle, so stale data never looks valid
	assign mem_rdata = (mem_out.req && !mem_out.we) ? mem[mem_out.addr] : idle_reg;

endmodule : storage_model

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "sste_defs.svh"

module testbench;

	logic clk, ce, sys_rst, ins_valid, reg_load, start_key, clear_key;
	logic ins_ready, done, halted, trap_lamp, unknown_op;
	sste_pkg::word_s ins_word, multquot_in, mem_rdata, multquot_register;
	sste_pkg::addr_t ins_loc, ins_y, instruction_counter;
	sste_pkg::acc_s acc_in, main_sum_register;
	sste_pkg::mem_req_s mem_out;
	logic [35:0] panel_keys;
	int bad_count, comparisons, cyc;

	typedef struct {
		logic [11:0] opc;
		sste_pkg::word_s want;
	} store_row_s;
	store_row_s rows [10];
	sste_pkg::acc_s ac = {2'b11, 36'h5_3c96_a50f};
	sste_pkg::word_s mq = 36'ha_c3e1_9b74;
	sste_pkg::word_s old = 36'h3_9e4d_2f68;
	sste_pkg::acc_s zacc [5] = '{38'h0, 38'h08_0000_0000, 38'h10_0000_0000, 38'h20_0000_0000, 38'h1};
	logic zjump [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

	store_swap_transfer_exec dut (.clk(clk), .ce(ce), .sys_rst(sys_rst), .ins_valid(ins_valid),
		.ins_word(ins_word), .ins_loc(ins_loc), .ins_y(ins_y), .reg_load(reg_load), .acc_in(acc_in),
		.multquot_in(multquot_in), .mem_rdata(mem_rdata), .panel_keys(panel_keys), .start_key(start_key),
		.clear_key(clear_key), .ins_ready(ins_ready), .mem_out(mem_out), .main_sum_register(main_sum_register),
		.multquot_register(multquot_register), .done(done), .instruction_counter(instruction_counter),
		.halted(halted), .trap_lamp(trap_lamp), .unknown_op(unknown_op));

	storage_model mem_model (.clk(clk), .mem_out(mem_out), .mem_rdata(mem_rdata));

	always #10 clk = ~clk;

	// =====================================================
	// shared tasks
	task automatic finish_test();
		if (bad_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		comparisons++;
		if (seen !== want) begin
			bad_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	function automatic sste_pkg::word_s mk(input logic [11:0] opc, input logic [14:0] a);
		return {opc, 6'h00, 3'h0, a};
	endfunction : mk

	// done may come with the take edge itself, so look 1 ns after it first
	task automatic wait_done();
		cyc = 1;
		#1;
		while (done !== 1'b1 && cyc < 20) begin
			@(posedge clk);
			#1;
			cyc++;
		end
		if (done !== 1'b1) begin
			bad_count++;
			finish_test();
		end
	endtask : wait_done

	task automatic run(input logic [11:0] opc, input logic [14:0] a, input logic [14:0] loc,
		input logic [14:0] y, input bit wt);
		int n;
		n = 0;
		@(posedge clk);
		ins_valid <= 1'b1;
		ins_word <= mk(opc, a);
		ins_loc <= loc;
		ins_y <= y;
		do begin
			@(posedge clk);
			n++;
		end while (ins_ready !== 1'b1 && n < 40);
		ins_valid <= 1'b0;
		if (wt) begin
			wait_done();
		end
	endtask : run

	task automatic setregs(input sste_pkg::acc_s a, input sste_pkg::word_s m);
		@(posedge clk);
		reg_load <= 1'b1;
		acc_in <= a;
		multquot_in <= m;
		@(posedge clk);
		reg_load <= 1'b0;
	endtask : setregs

	task automatic press_start();
		@(posedge clk);
		start_key <= 1'b1;
		wait_done();
		@(posedge clk);
		start_key <= 1'b0;
		#1;
	endtask : press_start

	// a memory write lands one edge after done
	task automatic settle();
		@(posedge clk);
		#1;
	endtask : settle

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		finish_test();
	end

	// =====================================================
	// main sequence
	initial begin
		clk = 1'b0;
		ce = 1'b1;
		sys_rst = 1'b1;
		{ins_valid, reg_load, start_key, clear_key} = 4'h0;
		ins_word = 36'h0_0000_0000;
		{ins_loc, ins_y} = 30'h0;
		acc_in = 38'h0;
		multquot_in = 36'h0_0000_0000;
		panel_keys = 36'h0_0000_0000;
		rows[0] = '{`OPC_ST_MULTQUOT, mq};
		rows[1] = '{`OPC_ST_LEFT_HALF, {mq[35:18], old[17:0]}};
		rows[2] = '{`OPC_ST_ACC_WORD, ac.w};
		rows[3] = '{`OPC_ST_LOGICAL, {ac.p, ac.w[34:0]}};
		rows[4] = '{`OPC_ST_PREFIX, {ac.p, ac.w[34:33], old[32:0]}};
		rows[5] = '{`OPC_ST_DECREMENT, {old[35:33], ac.w[32:18], old[17:0]}};
		rows[6] = '{`OPC_ST_TAG, {old[35:18], ac.w[17:15], old[14:0]}};
		rows[7] = '{`OPC_ST_ADDRESS, {old[35:15], ac.w[14:0]}};
		rows[8] = '{`OPC_ST_LOCATION, {old[35:15], 15'h0201}};
		rows[9] = '{`OPC_ST_ZERO, 36'h0_0000_0000};
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		check(64'(ins_ready), 64'(1'b1));
		check(64'(trap_lamp), 64'(1'b0));

		foreach (rows[i]) begin
			setregs(ac, mq);
			mem_model.mem[15'h0100] = old;
			run(rows[i].opc, 15'h0100, 15'h0200, 15'h0100, 1'b1);
			check(64'(cyc), 64'(2));
			check(64'(instruction_counter), 64'(15'h0201));
			settle();
			check(64'(mem_model.mem[15'h0100]), 64'(rows[i].want));
			check(64'(main_sum_register), 64'(ac));
			check(64'(multquot_register), 64'(mq));
		end

		// =====================================================
		// hand-written cases
		mem_model.mem[0] = old;
		run({3'h5, 9'h1ab}, 15'h7fff, 15'h0300, 15'h0123, 1'b1);
		check(64'(cyc), 64'(2));
		check(64'(instruction_counter), 64'(15'h0002));
		settle();
		check(64'(mem_model.mem[0]), 64'({old[35:15], 15'h0301}));

		setregs(ac, mq);
		run(`OPC_SWAP, 15'h0, 15'h0400, 15'h0, 1'b1);
		check(64'(cyc), 64'(1));
		check(64'(main_sum_register), 64'({2'b00, mq}));
		check(64'(multquot_register), 64'(ac.w));
		setregs(ac, mq);
		run(`OPC_SWAP_LOGICAL, 15'h0, 15'h0410, 15'h0, 1'b1);
		check(64'(main_sum_register), 64'({1'b0, mq[35], 1'b0, mq[34:0]}));
		check(64'(multquot_register), 64'({ac.p, ac.w[34:0]}));

		// keys pass a two-flop sync before the load can see them
		@(posedge clk);
		panel_keys <= 36'hc_5a3f_0e91;
		repeat (3) @(posedge clk);
		run(`OPC_PANEL_TRAP_ON, {2'b00, `SEL_PANEL}, 15'h0420, 15'h0, 1'b1);
		check(64'(multquot_register), 64'(36'hc_5a3f_0e91));

		run(`OPC_NOP, 15'h0, 15'h0500, 15'h0777, 1'b1);
		check(64'(cyc), 64'(2));
		check(64'(instruction_counter), 64'(15'h0501));

		run(`OPC_HALT_PROCEED, 15'h0, 15'h0600, 15'h0777, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		check(64'(halted), 64'(1'b1));
		check(64'(instruction_counter), 64'(15'h0601));
		press_start();
		check(64'(halted), 64'(1'b0));
		check(64'(instruction_counter), 64'(15'h0601));

		run(`OPC_HALT_JUMP, 15'h0345, 15'h0700, 15'h0345, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		check(64'(halted), 64'(1'b1));
		check(64'(instruction_counter), 64'(15'h0700));
		press_start();
		check(64'(instruction_counter), 64'(15'h0345));

		mem_model.mem[15'h0800] = mk(`OPC_JUMP, 15'h0456);
		run(`OPC_PERFORM, 15'h0800, 15'h0810, 15'h0800, 1'b1);
		check(64'(instruction_counter), 64'(15'h0456));
		mem_model.mem[15'h0801] = mk(`OPC_ST_ZERO, 15'h0820);
		mem_model.mem[15'h0820] = old;
		run(`OPC_PERFORM, 15'h0801, 15'h0811, 15'h0801, 1'b1);
		check(64'(instruction_counter), 64'(15'h0812));
		settle();
		check(64'(mem_model.mem[15'h0820]), 64'(36'h0_0000_0000));

		run(`OPC_JUMP, 15'h0900, 15'h0910, 15'h0900, 1'b1);
		check(64'(cyc), 64'(1));
		check(64'(instruction_counter), 64'(15'h0900));

		// sign is outside the zero test
		for (int i = 0; i < 5; i++) begin
			setregs(zacc[i], mq);
			run(`OPC_JUMP_ZERO, 15'h0a00, 15'h0a10, 15'h0a00, 1'b1);
			check(64'(instruction_counter), 64'(zjump[i] ? 15'h0a00 : 15'h0a11));
		end

		// index-modified selector must not enter trap mode
		run(`OPC_PANEL_TRAP_ON, 15'h0006, 15'h0b00, 15'h0006, 1'b1);
		check(64'(unknown_op), 64'(1'b1));
		check(64'(trap_lamp), 64'(1'b0));
		run(`OPC_PANEL_TRAP_ON, {2'b00, `SEL_TRAP}, 15'h0b10, 15'h0, 1'b1);
		check(64'(trap_lamp), 64'(1'b1));

		mem_model.mem[0] = old;
		run(`OPC_JUMP, 15'h0c00, 15'h0c10, 15'h0c00, 1'b1);
		check(64'(cyc), 64'(2));
		check(64'(instruction_counter), 64'(15'h0001));
		settle();
		check(64'(mem_model.mem[0]), 64'({old[35:15], 15'h0c10}));
		setregs(zacc[2], mq);
		run(`OPC_JUMP_ZERO, 15'h0c00, 15'h0c20, 15'h0c00, 1'b1);
		check(64'(instruction_counter), 64'(15'h0c21));
		settle();
		check(64'(mem_model.mem[0]), 64'({old[35:15], 15'h0c20}));

		mem_model.mem[0] = old;
		run(`OPC_JUMP_BYPASS, 15'h0d00, 15'h0c30, 15'h0d00, 1'b1);
		check(64'(cyc), 64'(1));
		check(64'(instruction_counter), 64'(15'h0d00));
		settle();
		check(64'(mem_model.mem[0]), 64'(old));

		run(`OPC_TRAP_OFF, {2'b00, `SEL_TRAP}, 15'h0e00, 15'h0, 1'b1);
		check(64'(trap_lamp), 64'(1'b0));
		run(`OPC_JUMP, 15'h0e40, 15'h0e10, 15'h0e40, 1'b1);
		check(64'(cyc), 64'(1));
		check(64'(instruction_counter), 64'(15'h0e40));

		run(`OPC_PANEL_TRAP_ON, {2'b00, `SEL_TRAP}, 15'h0e20, 15'h0, 1'b1);
		check(64'(trap_lamp), 64'(1'b1));
		@(posedge clk);
		clear_key <= 1'b1;
		repeat (4) @(posedge clk);
		clear_key <= 1'b0;
		#1;
		check(64'(trap_lamp), 64'(1'b0));
		finish_test();
	end

endmodule : testbench

// ### hw/store_swap_transfer_exec.sv
`timescale 1ns/1ps
`include "sste_defs.svh"

module store_swap_transfer_exec (
	input wire logic clk,
	input wire logic ce,
	input wire logic sys_rst,
	input wire logic ins_valid,
	input wire sste_pkg::word_s ins_word,
	input wire sste_pkg::addr_t ins_loc,
	input wire sste_pkg::addr_t ins_y,
	input wire logic reg_load,
	input wire sste_pkg::acc_s acc_in,
	input wire sste_pkg::word_s multquot_in,
	input wire sste_pkg::word_s mem_rdata,
	input wire logic [35:0] panel_keys,
	input wire logic start_key,
	input wire logic clear_key,
	output logic ins_ready,
	output sste_pkg::mem_req_s mem_out,
	output sste_pkg::acc_s main_sum_register,
	output sste_pkg::word_s multquot_register,
	output logic done,
	output sste_pkg::addr_t instruction_counter,
	output logic halted,
	output logic trap_lamp,
	output logic unknown_op
);

	// =====================================================
	// decode and merge helpers
	function automatic sste_pkg::op_e decode(input sste_pkg::word_s w);
		logic [11:0] opc;
		logic [12:0] sel;
		opc = {w.sign, w.pfx, w.dec[14:6]};
		sel = w.addr[12:0];
		decode = sste_pkg::OP_NONE;
		if ({w.sign, w.pfx} == `STR_PREFIX) begin
			decode = sste_pkg::OP_ST_LOC_TRAP;
		end else begin
			case (opc)
				`OPC_ST_MULTQUOT: decode = sste_pkg::OP_ST_MULTQUOT;
				`OPC_ST_LEFT_HALF: decode = sste_pkg::OP_ST_LEFT_HALF;
				`OPC_ST_ACC_WORD: decode = sste_pkg::OP_ST_ACC_WORD;
				`OPC_ST_LOGICAL: decode = sste_pkg::OP_ST_LOGICAL;
				`OPC_ST_PREFIX: decode = sste_pkg::OP_ST_PREFIX;
				`OPC_ST_DECREMENT: decode = sste_pkg::OP_ST_DECREMENT;
				`OPC_ST_TAG: decode = sste_pkg::OP_ST_TAG;
				`OPC_ST_ADDRESS: decode = sste_pkg::OP_ST_ADDRESS;
				`OPC_ST_LOCATION: decode = sste_pkg::OP_ST_LOCATION;
				`OPC_ST_ZERO: decode = sste_pkg::OP_ST_ZERO;
				`OPC_SWAP: decode = sste_pkg::OP_SWAP;
				`OPC_SWAP_LOGICAL: decode = sste_pkg::OP_SWAP_LOGICAL;
				// indexing may alter bits 23-35 and so the operation
				`OPC_PANEL_TRAP_ON: begin
					if (sel == `SEL_PANEL) begin
						decode = sste_pkg::OP_LOAD_PANEL;
					end else if (sel == `SEL_TRAP) begin
						decode = sste_pkg::OP_TRAP_ENTER;
					end
				end
				`OPC_TRAP_OFF: begin
					if (sel == `SEL_TRAP) begin
						decode = sste_pkg::OP_TRAP_LEAVE;
					end
				end
				`OPC_NOP: decode = sste_pkg::OP_NOP;
				`OPC_HALT_PROCEED: decode = sste_pkg::OP_HALT_PROCEED;
				`OPC_HALT_JUMP: decode = sste_pkg::OP_HALT_JUMP;
				`OPC_PERFORM: decode = sste_pkg::OP_PERFORM_TARGET;
				`OPC_JUMP: decode = sste_pkg::OP_JUMP;
				`OPC_JUMP_BYPASS: decode = sste_pkg::OP_JUMP_BYPASS;
				`OPC_JUMP_ZERO: decode = sste_pkg::OP_JUMP_ZERO;
				default: ;
			endcase
		end
	endfunction : decode

	function automatic logic is_store(input sste_pkg::op_e op);
		is_store = op inside {sste_pkg::OP_ST_MULTQUOT, sste_pkg::OP_ST_LEFT_HALF, sste_pkg::OP_ST_ACC_WORD,
			sste_pkg::OP_ST_LOGICAL, sste_pkg::OP_ST_PREFIX, sste_pkg::OP_ST_DECREMENT, sste_pkg::OP_ST_TAG,
			sste_pkg::OP_ST_ADDRESS, sste_pkg::OP_ST_LOCATION, sste_pkg::OP_ST_LOC_TRAP, sste_pkg::OP_ST_ZERO};
	endfunction : is_store

	// old word comes back from storage; only the named fields change
	function automatic sste_pkg::word_s merge(input sste_pkg::op_e op, input sste_pkg::word_s old,
			input sste_pkg::acc_s a, input sste_pkg::word_s m, input sste_pkg::addr_t loc);
		merge = old;
		case (op)
			sste_pkg::OP_ST_MULTQUOT: merge = m;
			sste_pkg::OP_ST_LEFT_HALF: begin
				merge.sign = m.sign;
				merge.pfx = m.pfx;
				merge.dec = m.dec;
			end
			sste_pkg::OP_ST_ACC_WORD: merge = a.w;
			sste_pkg::OP_ST_LOGICAL: begin
				merge = a.w;
				merge.sign = a.p;
			end
			sste_pkg::OP_ST_PREFIX: begin
				merge.sign = a.p;
				merge.pfx = a.w.pfx;
			end
			sste_pkg::OP_ST_DECREMENT: merge.dec = a.w.dec;
			sste_pkg::OP_ST_TAG: merge.tag = a.w.tag;
			sste_pkg::OP_ST_ADDRESS: merge.addr = a.w.addr;
			sste_pkg::OP_ST_LOCATION, sste_pkg::OP_ST_LOC_TRAP: merge.addr = loc + `PC_STEP;
			sste_pkg::OP_ST_ZERO: merge = '0;
			default: merge.addr = loc;
		endcase
	endfunction : merge

	// =====================================================
	// console pin synchronisers
	logic [35:0] keys_s1_reg, keys_s2_reg;
	logic start_s1_reg, start_s2_reg, start_s3_reg;
	logic clear_s1_reg, clear_s2_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			keys_s1_reg <= '0;
			keys_s2_reg <= '0;
			start_s1_reg <= 1'b0;
			start_s2_reg <= 1'b0;
			start_s3_reg <= 1'b0;
			clear_s1_reg <= 1'b0;
			clear_s2_reg <= 1'b0;
		end else if (ce) begin
			keys_s1_reg <= panel_keys;
			keys_s2_reg <= keys_s1_reg;
			start_s1_reg <= start_key;
			start_s2_reg <= start_s1_reg;
			start_s3_reg <= start_s2_reg;
			clear_s1_reg <= clear_key;
			clear_s2_reg <= clear_s1_reg;
		end
	end

	// =====================================================
	// sequencing
	sste_pkg::state_e st_reg, st_next;
	sste_pkg::op_e op_reg, op_next, op_now;
	sste_pkg::addr_t loc_reg, loc_next, y_reg, y_next, cur_loc, cur_y, fin_pc, addr_next;
	sste_pkg::word_s cur_w;
	logic taken_reg, taken_next, launch, acc_zero, cond, start_edge, fin, rd, wr, halt_next, trap_mode;

	assign start_edge = start_s2_reg & ~start_s3_reg;
	// a performed target comes straight from storage and is not indexed
	assign launch = ce & ((st_reg == sste_pkg::ST_IDLE & ins_valid)
		| (st_reg == sste_pkg::ST_READ & op_reg == sste_pkg::OP_PERFORM_TARGET));
	assign cur_w = (st_reg == sste_pkg::ST_READ) ? mem_rdata : ins_word;
	assign cur_y = (st_reg == sste_pkg::ST_READ) ? mem_rdata.addr : ins_y;
	assign cur_loc = (st_reg == sste_pkg::ST_READ) ? loc_reg : ins_loc;
	assign op_now = decode(cur_w);
	assign acc_zero = ~main_sum_register.q & ~main_sum_register.p
		& ~|{main_sum_register.w.pfx, main_sum_register.w.dec, main_sum_register.w.tag,
		main_sum_register.w.addr};
	assign cond = (op_now == sste_pkg::OP_JUMP_ZERO) ? acc_zero : 1'b1;

	always_comb begin
		st_next = st_reg;
		op_next = op_reg;
		loc_next = loc_reg;
		y_next = y_reg;
		taken_next = taken_reg;
		fin = 1'b0;
		fin_pc = loc_reg + `PC_STEP;
		rd = 1'b0;
		wr = 1'b0;
		addr_next = mem_out.addr;
		halt_next = halted;
		unique case (st_reg)
			sste_pkg::ST_IDLE: ;
			sste_pkg::ST_READ: begin
				if (op_reg != sste_pkg::OP_PERFORM_TARGET) begin
					wr = 1'b1;
					fin = 1'b1;
					st_next = sste_pkg::ST_IDLE;
					if (op_reg == sste_pkg::OP_ST_LOC_TRAP) begin
						fin_pc = `LOC_STR_GO;
					end else if (!is_store(op_reg) && taken_reg) begin
						fin_pc = `LOC_TRAP_GO;
					end
				end
			end
			sste_pkg::ST_WAIT: begin
				if (op_reg inside {sste_pkg::OP_HALT_PROCEED, sste_pkg::OP_HALT_JUMP}) begin
					st_next = sste_pkg::ST_HALT;
					halt_next = 1'b1;
				end else begin
					fin = 1'b1;
					st_next = sste_pkg::ST_IDLE;
				end
			end
			sste_pkg::ST_HALT: begin
				if (start_edge) begin
					halt_next = 1'b0;
					if (op_reg == sste_pkg::OP_HALT_PROCEED) begin
						fin = 1'b1;
						st_next = sste_pkg::ST_IDLE;
					end else if (trap_mode) begin
						rd = 1'b1;
						addr_next = `LOC_TRAP_SAVE;
						taken_next = 1'b1;
						st_next = sste_pkg::ST_READ;
					end else begin
						fin = 1'b1;
						fin_pc = y_reg;
						st_next = sste_pkg::ST_IDLE;
					end
				end
			end
		endcase
		if (launch) begin
			op_next = op_now;
			loc_next = cur_loc;
			y_next = cur_y;
			taken_next = cond;
			st_next = sste_pkg::ST_IDLE;
			if (op_now == sste_pkg::OP_PERFORM_TARGET) begin
				rd = 1'b1;
				addr_next = cur_y;
				st_next = sste_pkg::ST_READ;
			end else if (is_store(op_now)) begin
				rd = 1'b1;
				addr_next = (op_now == sste_pkg::OP_ST_LOC_TRAP) ? `LOC_TRAP_SAVE : cur_y;
				st_next = sste_pkg::ST_READ;
			end else if (trap_mode && op_now inside {sste_pkg::OP_JUMP, sste_pkg::OP_JUMP_ZERO}) begin
				rd = 1'b1;
				addr_next = `LOC_TRAP_SAVE;
				st_next = sste_pkg::ST_READ;
			end else if (op_now inside {sste_pkg::OP_NOP, sste_pkg::OP_HALT_PROCEED, sste_pkg::OP_HALT_JUMP,
					sste_pkg::OP_LOAD_PANEL, sste_pkg::OP_TRAP_ENTER, sste_pkg::OP_TRAP_LEAVE}) begin
				st_next = sste_pkg::ST_WAIT;
			end else begin
				fin = 1'b1;
				fin_pc = cur_loc + `PC_STEP;
				if (op_now inside {sste_pkg::OP_JUMP, sste_pkg::OP_JUMP_ZERO, sste_pkg::OP_JUMP_BYPASS} && cond) begin
					fin_pc = cur_y;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= sste_pkg::ST_IDLE;
			op_reg <= sste_pkg::OP_NONE;
			loc_reg <= '0;
			y_reg <= '0;
			taken_reg <= 1'b0;
			ins_ready <= 1'b1;
		end else if (ce) begin
			st_reg <= st_next;
			op_reg <= op_next;
			loc_reg <= loc_next;
			y_reg <= y_next;
			taken_reg <= taken_next;
			ins_ready <= (st_next == sste_pkg::ST_IDLE);
		end
	end

	// =====================================================
	// storage port: read first, write back merged word
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_out <= '0;
		end else if (ce) begin
			mem_out.req <= rd | wr;
			mem_out.we <= wr;
			mem_out.addr <= addr_next;
			if (wr) begin
				mem_out.wdata <= merge(op_reg, mem_rdata, main_sum_register, multquot_register, loc_reg);
			end
		end
	end

	// =====================================================
	// completion and console status
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			done <= 1'b0;
			instruction_counter <= '0;
			halted <= 1'b0;
			unknown_op <= 1'b0;
		end else if (ce) begin
			done <= fin;
			if (fin) begin
				instruction_counter <= fin_pc;
			end
			if (launch && op_now inside {sste_pkg::OP_HALT_PROCEED, sste_pkg::OP_HALT_JUMP}) begin
				instruction_counter <= (op_now == sste_pkg::OP_HALT_JUMP) ? cur_loc : cur_loc + `PC_STEP;
			end
			halted <= halt_next;
			unknown_op <= launch & (op_now == sste_pkg::OP_NONE);
		end
	end

	// =====================================================
	// arithmetic registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			main_sum_register <= '0;
			multquot_register <= '0;
		end else if (ce) begin
			if (launch && op_now == sste_pkg::OP_SWAP) begin
				main_sum_register <= {2'b00, multquot_register};
				multquot_register <= main_sum_register.w;
			end else if (launch && op_now == sste_pkg::OP_SWAP_LOGICAL) begin
				main_sum_register <= {2'b00, multquot_register};
				main_sum_register.p <= multquot_register.sign;
				main_sum_register.w.sign <= 1'b0;
				multquot_register <= main_sum_register.w;
				multquot_register.sign <= main_sum_register.p;
			end else if (launch && op_now == sste_pkg::OP_LOAD_PANEL) begin
				multquot_register <= keys_s2_reg;
			end else if (reg_load && st_reg == sste_pkg::ST_IDLE) begin
				main_sum_register <= acc_in;
				multquot_register <= multquot_in;
			end
		end
	end

	// =====================================================
	// transfer trapping mode; the clear key wins over entry
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trap_mode <= 1'b0;
		end else if (ce) begin
			if (clear_s2_reg) begin
				trap_mode <= 1'b0;
			end else if (launch && op_now == sste_pkg::OP_TRAP_ENTER) begin
				trap_mode <= 1'b1;
			end else if (launch && op_now == sste_pkg::OP_TRAP_LEAVE) begin
				trap_mode <= 1'b0;
			end
		end
	end
	assign trap_lamp = trap_mode;

	// =====================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || !ce);

	a_store_two_cycles: assert property (launch && is_store(op_now) && !sys_rst |=>
		mem_out.req && !mem_out.we ##1 mem_out.req && mem_out.we && done) else $error("store not two cycles");
	a_full_store_word: assert property (st_reg == sste_pkg::ST_READ && op_reg == sste_pkg::OP_ST_MULTQUOT
		|=> mem_out.wdata == $past(multquot_register) && $stable(multquot_register)) else $error("full store bad");
	a_left_half_keep: assert property (st_reg == sste_pkg::ST_READ && op_reg == sste_pkg::OP_ST_LEFT_HALF
		|=> mem_out.wdata.addr == $past(mem_rdata.addr) && mem_out.wdata.tag == $past(mem_rdata.tag)
		&& mem_out.wdata.sign == $past(multquot_register.sign)) else $error("left half store bad");
	a_logical_sign: assert property (st_reg == sste_pkg::ST_READ && op_reg == sste_pkg::OP_ST_LOGICAL
		|=> mem_out.wdata.sign == $past(main_sum_register.p)) else $error("logical store sign bad");
	a_zero_store: assert property (st_reg == sste_pkg::ST_READ && op_reg == sste_pkg::OP_ST_ZERO
		|=> mem_out.wdata == '0) else $error("store zero bad");
	a_loc_trap_vector: assert property (launch && op_now == sste_pkg::OP_ST_LOC_TRAP
		|=> mem_out.addr == `LOC_TRAP_SAVE ##1 done && instruction_counter == `LOC_STR_GO) else $error("str bad");
	a_swap_one_cycle: assert property (launch && op_now == sste_pkg::OP_SWAP |=> done
		&& main_sum_register.w == $past(multquot_register) && !main_sum_register.p && !main_sum_register.q)
		else $error("swap bad");
	a_zero_jump: assert property (launch && op_now == sste_pkg::OP_JUMP_ZERO && !trap_mode && acc_zero
		|=> done && instruction_counter == $past(cur_y)) else $error("zero jump missed");
	a_trap_vector: assert property (launch && trap_mode && op_now == sste_pkg::OP_JUMP
		|=> !done && mem_out.addr == `LOC_TRAP_SAVE ##1 done && mem_out.we
		&& instruction_counter == `LOC_TRAP_GO) else $error("trapped jump bad");
	a_bypass_untrapped: assert property (launch && op_now == sste_pkg::OP_JUMP_BYPASS
		|=> done && !mem_out.req && instruction_counter == $past(cur_y)) else $error("bypass trapped");
	a_leave_trap: assert property (launch && op_now == sste_pkg::OP_TRAP_LEAVE && !clear_s2_reg
		|=> !trap_lamp) else $error("trap mode kept");

	c_field_store: cover property (launch && op_now == sste_pkg::OP_ST_ADDRESS ##2 done);
	c_trapped_jump: cover property (launch && trap_mode && op_now == sste_pkg::OP_JUMP_ZERO ##2 done);
	c_halt_resume: cover property (halted && start_edge);
	c_perform: cover property (st_reg == sste_pkg::ST_READ && op_reg == sste_pkg::OP_PERFORM_TARGET && launch);

endmodule : store_swap_transfer_exec

// ### inc/sste_defs.svh
`ifndef SSTE_DEFS_SVH
`define SSTE_DEFS_SVH

// =====================================================
// operation codes: sign then bits 1-11
`define OPC_ST_MULTQUOT 12'h980
`define OPC_ST_LEFT_HALF 12'h990
`define OPC_ST_ACC_WORD 12'h181
`define OPC_ST_LOGICAL 12'h182
`define OPC_ST_PREFIX 12'h198
`define OPC_ST_DECREMENT 12'h192
`define OPC_ST_TAG 12'h195
`define OPC_ST_ADDRESS 12'h191
`define OPC_ST_LOCATION 12'h995
`define OPC_ST_ZERO 12'h180
`define OPC_SWAP 12'h059
`define OPC_SWAP_LOGICAL 12'h858
`define OPC_PANEL_TRAP_ON 12'h1f0
`define OPC_TRAP_OFF 12'h9f0
`define OPC_NOP 12'h1f1
`define OPC_HALT_PROCEED 12'h110
`define OPC_HALT_JUMP 12'h000
`define OPC_PERFORM 12'h152
`define OPC_JUMP 12'h010
`define OPC_JUMP_BYPASS 12'h011
`define OPC_JUMP_ZERO 12'h040
// sign and bits 1-2 of the location-and-trap store
`define STR_PREFIX 3'h5
// bits 23-35 that extend the operation code
`define SEL_PANEL 13'h0004
`define SEL_TRAP 13'h0007

// =====================================================
// fixed storage locations and counter step
`define LOC_TRAP_SAVE 15'h0000
`define LOC_TRAP_GO 15'h0001
`define LOC_STR_GO 15'h0002
`define PC_STEP 15'h0001

`endif

// ### inc/sste_pkg.sv
package sste_pkg;

	typedef logic [14:0] addr_t;

	// sign, bits 1-2, decrement 3-17, tag 18-20, address 21-35
	typedef struct packed {
		logic sign;
		logic [1:0] pfx;
		logic [14:0] dec;
		logic [2:0] tag;
		logic [14:0] addr;
	} word_s;

	typedef struct packed {
		logic q;
		logic p;
		word_s w;
	} acc_s;

	typedef struct packed {
		logic req;
		logic we;
		addr_t addr;
		word_s wdata;
	} mem_req_s;

	typedef enum logic [4:0] {
		OP_ST_MULTQUOT, OP_ST_LEFT_HALF, OP_ST_ACC_WORD, OP_ST_LOGICAL, OP_ST_PREFIX,
		OP_ST_DECREMENT, OP_ST_TAG, OP_ST_ADDRESS, OP_ST_LOCATION, OP_ST_LOC_TRAP,
		OP_ST_ZERO, OP_SWAP, OP_SWAP_LOGICAL, OP_LOAD_PANEL, OP_NOP, OP_HALT_PROCEED,
		OP_HALT_JUMP, OP_PERFORM_TARGET, OP_JUMP, OP_TRAP_ENTER, OP_TRAP_LEAVE,
		OP_JUMP_BYPASS, OP_JUMP_ZERO, OP_NONE
	} op_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_WAIT = 4'h4,
		ST_HALT = 4'h8
	} state_e;

endpackage : sste_pkg
